// [design/fcp_defines.svh]
// fcp_defines.svh: register offsets, field positions, reset values and counts of the flash
// current protection block.
// assumes an APB slave with 32-bit data and word-aligned registers.
`ifndef FCP_DEFINES_SVH
`define FCP_DEFINES_SVH

`define FCP_OFF_CTRL        12'h000
`define FCP_OFF_SINK_A      12'h004
`define FCP_OFF_SINK_B      12'h008
`define FCP_OFF_BLANK       12'h00C
`define FCP_OFF_TEMP        12'h010
`define FCP_OFF_LOWBAT      12'h014
`define FCP_OFF_FAULT       12'h018
`define FCP_OFF_STATUS      12'h01C

`define FCP_CODE_W          5
`define FCP_CODE_MIN        5'h00
`define FCP_SINK_RST        5'h00
`define FCP_BLANK_POL_BIT   6
`define FCP_BLANK_RST       8'h00
`define FCP_TEMP_EN_BIT     3
`define FCP_TEMP_RST        4'h0
`define FCP_LB_RST          4'h0
`define FCP_HYST_OFF        2'h3
`define FCP_FLT_TEMP_BIT    3
`define FCP_FLT_OPEN_A_BIT  0
`define FCP_FLT_SHORT_A_BIT 1
`define FCP_FLT_OPEN_B_BIT  4
`define FCP_FLT_SHORT_B_BIT 5

// step interval choices in ns, picked by step_interval_sel
`define FCP_CLK_NS          5
`define FCP_STEP0_NS        1000
`define FCP_STEP1_NS        2000
`define FCP_STEP2_NS        4000
`define FCP_STEP3_NS        8000
// low-battery sample interval in ns
`define FCP_LB_NS           4000
`define FCP_SOFT_NS         2000
`define FCP_CNT_W           12

`endif

// [design/fcp_pkg.sv]
// fcp_pkg.sv: types shared by the flash current protection block.
// assumes fcp_defines.svh for the numeric constants.
`include "fcp_defines.svh"

package fcp_pkg;

    typedef logic [`FCP_CODE_W-1:0] fcp_code_t;

    typedef struct packed {
        logic lim_over;
        logic lowbat_low;
        logic lowbat_high;
        logic temp_low;
        logic open_a;
        logic short_a;
        logic open_b;
        logic short_b;
    } fcp_sense_t;

    typedef struct packed {
        fcp_code_t code_a;
        fcp_code_t code_b;
        logic      en_a;
        logic      en_b;
        logic      hiz;
        logic      boost_on;
        logic      soft_start;
    } fcp_drive_t;

    typedef enum logic [3:0] {
        FCP_ST_STANDBY = 4'h1,
        FCP_ST_SOFT    = 4'h2,
        FCP_ST_RUN     = 4'h4,
        FCP_ST_TERM    = 4'h8
    } fcp_state_t;

endpackage

// [design/fcp_ctrl.sv]
// fcp_ctrl.sv: digital control of the flash current sinks: transmit blank limiter,
// low-battery stepping, over-temperature termination, open/short latches, lockout.
// assumes APB master on pclk, presetn driven from the logic-supply lockout detector,
// analog comparators and the blank pin asynchronous to pclk.
//
// Notes on behaviour
// [RULE_01] blank start forces both sink codes to the lowest code at once.
// [RULE_02] then codes rise one LSB per step_interval_sel interval.
// [RULE_03] rising stops at programmed code; limit comparator high lowers one LSB.
// [RULE_04] while blank active keep stepping up or down by the comparator.
// [RULE_05] blank leaves stored sink registers and flash timer untouched.
// [RULE_06] blank release returns sinks straight to programmed codes.
// [RULE_07] blank polarity is bit 6 of blank_current_reg, reset active high.
// [RULE_08] three-bit threshold code in temperature control register.
// [RULE_09] temp below threshold in flash ends flash, sets sticky fault bit 3.
// [RULE_10] temp control bit 3 clear disables over-temperature termination.
// [RULE_11] low battery during flash or torch lowers sink code one step.
// [RULE_12] after each step wait one sample interval, resample, lower again.
// [RULE_13] above threshold plus hysteresis raises one step up to setting.
// [RULE_14] hysteresis field 11 keeps reduced code, no stepping back up.
// [RULE_15] low-battery loop runs for whole flash or torch event.
// [RULE_16] registers reset only by logic-supply lockout, not input lockout.
// [RULE_17] in logic lockout: registers reset, converter off, sinks high impedance.
// [RULE_18] valid logic supply: standby, sinks high impedance, bus accepted.
// [RULE_19] soft start restarts after lockout or converter re-enable. From TERM it goes to RUN without soft start if boost en is set, else STANDBY.
// [RULE_20] open/short monitoring only while that sink is enabled.
// [RULE_21] open/short fault sets sticky per-sink status bit.
// [RULE_22] host generates bus clock; device is a slave only.
// [RULE_23] comparator outputs synchronised before the stepping logic.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defines.svh"

module fcp_ctrl
    import fcp_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic            pready,
    output logic     [31:0] prdata,
    output logic            pslverr,
    input  wire logic       pa_blank_input,
    input  wire logic       in_uvlo,
    input  wire fcp_sense_t sense_in,
    output fcp_drive_t      drive_out,
    output logic      [2:0] temp_thresh_code
);

    localparam int STEP0_CYC = `FCP_STEP0_NS / `FCP_CLK_NS;
    localparam int STEP1_CYC = `FCP_STEP1_NS / `FCP_CLK_NS;
    localparam int STEP2_CYC = `FCP_STEP2_NS / `FCP_CLK_NS;
    localparam int STEP3_CYC = `FCP_STEP3_NS / `FCP_CLK_NS;
    localparam int LB_CYC    = `FCP_LB_NS / `FCP_CLK_NS;
    localparam int SOFT_CYC  = `FCP_SOFT_NS / `FCP_CLK_NS;

    function automatic logic [`FCP_CNT_W-1:0] step_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    step_cycles = `FCP_CNT_W'(STEP0_CYC - 1);
            2'h1:    step_cycles = `FCP_CNT_W'(STEP1_CYC - 1);
            2'h2:    step_cycles = `FCP_CNT_W'(STEP2_CYC - 1);
            default: step_cycles = `FCP_CNT_W'(STEP3_CYC - 1);
        endcase
    endfunction

    function automatic fcp_code_t code_up(input fcp_code_t c, input fcp_code_t lim);
        code_up = (c < lim) ? fcp_code_t'(c + 1'b1) : lim;
    endfunction

    function automatic fcp_code_t code_dn(input fcp_code_t c);
        code_dn = (c > `FCP_CODE_MIN) ? fcp_code_t'(c - 1'b1) : `FCP_CODE_MIN;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic             blank_s1_r, blank_s2_r;
    fcp_sense_t       sense_s1_r, sense_s2_r;
    logic             uvlo_s1_r, uvlo_s2_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_s1_r <= 1'b0;
            blank_s2_r <= 1'b0;
            sense_s1_r <= '0;
            sense_s2_r <= '0;
            uvlo_s1_r  <= 1'b0;
            uvlo_s2_r  <= 1'b0;
        end else begin
            blank_s1_r <= pa_blank_input;
            blank_s2_r <= blank_s1_r;
            sense_s1_r <= sense_in;
            sense_s2_r <= sense_s1_r; // RULE_23
            uvlo_s1_r  <= in_uvlo;
            uvlo_s2_r  <= uvlo_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers (reset only by presetn, the logic-supply lockout)
    // ctrl: [0] sink a en, [1] sink b en, [2] flash, [3] torch, [4] boost en
    logic      [4:0] ctrl_r, ctrl_nxt;
    fcp_code_t       set_a_r, set_a_nxt, set_b_r, set_b_nxt;
    logic      [7:0] blank_reg_r, blank_reg_nxt;
    logic      [3:0] temp_reg_r, temp_reg_nxt;
    logic      [3:0] lb_reg_r, lb_reg_nxt;
    logic      [5:0] fault_r, fault_nxt;
    logic            wr_en;
    logic     [31:0] rdata_nxt;
    logic      [5:0] flt_set, flt_clr;

    assign wr_en   = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        ctrl_nxt      = ctrl_r;
        set_a_nxt     = set_a_r;
        set_b_nxt     = set_b_r;
        blank_reg_nxt = blank_reg_r;
        temp_reg_nxt  = temp_reg_r;
        lb_reg_nxt    = lb_reg_r;
        flt_clr       = 6'h00;
        if (wr_en) begin
            case (paddr)
                `FCP_OFF_CTRL:   ctrl_nxt      = pwdata[4:0];
                `FCP_OFF_SINK_A: set_a_nxt     = pwdata[`FCP_CODE_W-1:0];
                `FCP_OFF_SINK_B: set_b_nxt     = pwdata[`FCP_CODE_W-1:0];
                `FCP_OFF_BLANK:  blank_reg_nxt = pwdata[7:0];
                `FCP_OFF_TEMP:   temp_reg_nxt  = pwdata[3:0]; // RULE_08
                `FCP_OFF_LOWBAT: lb_reg_nxt    = pwdata[3:0];
                `FCP_OFF_FAULT:  flt_clr       = pwdata[5:0];
                default: ;
            endcase
        end
        fault_nxt = (fault_r & ~flt_clr) | flt_set; // RULE_09 RULE_21
    end

    ////////////////////////////////////////////////////////////////////////
    // sink stepping state
    fcp_state_t      st_r, st_nxt;
    fcp_code_t       code_a_r, code_a_nxt, code_b_r, code_b_nxt;
    logic            blank_d_r, blank_d_nxt;
    logic [`FCP_CNT_W-1:0] step_cnt_r, step_cnt_nxt;
    logic [`FCP_CNT_W-1:0] lb_cnt_r, lb_cnt_nxt;
    logic [`FCP_CNT_W-1:0] soft_cnt_r, soft_cnt_nxt;
    logic            blank_act, event_on, lb_tick, step_tick, hyst_off;

    always_comb begin
        // RULE_07
        blank_act = blank_s2_r ^ blank_reg_r[`FCP_BLANK_POL_BIT];
        hyst_off  = (lb_reg_r[3:2] == `FCP_HYST_OFF);
        event_on  = (ctrl_r[2] | ctrl_r[3]) & (ctrl_r[0] | ctrl_r[1]);
        st_nxt       = st_r;
        code_a_nxt   = code_a_r;
        code_b_nxt   = code_b_r;
        blank_d_nxt  = blank_act;
        step_cnt_nxt = (step_cnt_r == '0) ? step_cycles(blank_reg_r[1:0]) : step_cnt_r - 1'b1;
        lb_cnt_nxt   = (lb_cnt_r == '0) ? `FCP_CNT_W'(LB_CYC - 1) : lb_cnt_r - 1'b1;
        soft_cnt_nxt = (soft_cnt_r == '0) ? '0 : soft_cnt_r - 1'b1;
        step_tick    = (step_cnt_r == '0);
        lb_tick      = (lb_cnt_r == '0);
        flt_set      = 6'h00;
        case (st_r)
            FCP_ST_STANDBY: begin
                code_a_nxt = set_a_r;
                code_b_nxt = set_b_r;
                if (ctrl_r[4] && !uvlo_s2_r) begin
                    st_nxt       = FCP_ST_SOFT; // RULE_19
                    soft_cnt_nxt = `FCP_CNT_W'(SOFT_CYC - 1);
                end
            end
            FCP_ST_SOFT: begin
                if (!ctrl_r[4] || uvlo_s2_r)
                    st_nxt = FCP_ST_STANDBY;
                else if (soft_cnt_r == '0)
                    st_nxt = FCP_ST_RUN;
            end
            FCP_ST_RUN: begin
                if (!ctrl_r[4] || uvlo_s2_r) begin
                    st_nxt = FCP_ST_STANDBY; // RULE_19
                end else if (ctrl_r[2] && temp_reg_r[`FCP_TEMP_EN_BIT]
                             && sense_s2_r.temp_low) begin
                    st_nxt = FCP_ST_TERM; // RULE_09 RULE_10
                    flt_set[`FCP_FLT_TEMP_BIT] = 1'b1;
                end else if (blank_act && !blank_d_r) begin
                    code_a_nxt   = `FCP_CODE_MIN; // RULE_01
                    code_b_nxt   = `FCP_CODE_MIN;
                    step_cnt_nxt = step_cycles(blank_reg_r[1:0]);
                end else if (blank_act) begin
                    if (sense_s2_r.lim_over) begin
                        code_a_nxt = code_dn(code_a_r); // RULE_03 RULE_04
                        code_b_nxt = code_dn(code_b_r);
                    end else if (step_tick) begin
                        code_a_nxt = code_up(code_a_r, set_a_r); // RULE_02 RULE_03
                        code_b_nxt = code_up(code_b_r, set_b_r);
                    end
                end else if (blank_d_r) begin
                    code_a_nxt = set_a_r; // RULE_06
                    code_b_nxt = set_b_r;
                end else if (event_on && lb_tick) begin // RULE_15
                    if (sense_s2_r.lowbat_low) begin
                        code_a_nxt = code_dn(code_a_r); // RULE_11 RULE_12
                        code_b_nxt = code_dn(code_b_r);
                    end else if (sense_s2_r.lowbat_high && !hyst_off) begin
                        code_a_nxt = code_up(code_a_r, set_a_r); // RULE_13 RULE_14
                        code_b_nxt = code_up(code_b_r, set_b_r);
                    end
                end else if (!event_on) begin
                    code_a_nxt = set_a_r;
                    code_b_nxt = set_b_r;
                end
            end
            FCP_ST_TERM: begin
                if (!ctrl_r[2])
                    st_nxt = ctrl_r[4] ? FCP_ST_RUN : FCP_ST_STANDBY;
            end
            default: st_nxt = FCP_ST_STANDBY;
        endcase
        // RULE_20 RULE_21
        if (st_r == FCP_ST_RUN && event_on && ctrl_r[0]) begin
            flt_set[`FCP_FLT_OPEN_A_BIT]  = sense_s2_r.open_a;
            flt_set[`FCP_FLT_SHORT_A_BIT] = sense_s2_r.short_a;
        end
        if (st_r == FCP_ST_RUN && event_on && ctrl_r[1]) begin
            flt_set[`FCP_FLT_OPEN_B_BIT]  = sense_s2_r.open_b;
            flt_set[`FCP_FLT_SHORT_B_BIT] = sense_s2_r.short_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `FCP_OFF_CTRL:   rdata_nxt = {27'h0, ctrl_r};
            `FCP_OFF_SINK_A: rdata_nxt = {27'h0, set_a_r};
            `FCP_OFF_SINK_B: rdata_nxt = {27'h0, set_b_r};
            `FCP_OFF_BLANK:  rdata_nxt = {24'h0, blank_reg_r};
            `FCP_OFF_TEMP:   rdata_nxt = {28'h0, temp_reg_r};
            `FCP_OFF_LOWBAT: rdata_nxt = {28'h0, lb_reg_r};
            `FCP_OFF_FAULT:  rdata_nxt = {26'h0, fault_r};
            `FCP_OFF_STATUS: rdata_nxt = {18'h0, st_r, code_b_r, code_a_r};
            default:         rdata_nxt = 32'h0000_0000;
        endcase
    end

    assign prdata = rdata_nxt;

    ////////////////////////////////////////////////////////////////////////
    // registering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin // RULE_16 RULE_17
            ctrl_r      <= 5'h00;
            set_a_r     <= `FCP_SINK_RST;
            set_b_r     <= `FCP_SINK_RST;
            blank_reg_r <= `FCP_BLANK_RST;
            temp_reg_r  <= `FCP_TEMP_RST;
            lb_reg_r    <= `FCP_LB_RST;
            fault_r     <= 6'h00;
            st_r        <= FCP_ST_STANDBY; // RULE_18
            code_a_r    <= `FCP_CODE_MIN;
            code_b_r    <= `FCP_CODE_MIN;
            blank_d_r   <= 1'b0;
            step_cnt_r  <= '0;
            lb_cnt_r    <= '0;
            soft_cnt_r  <= '0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            set_a_r     <= set_a_nxt; // RULE_05
            set_b_r     <= set_b_nxt;
            blank_reg_r <= blank_reg_nxt;
            temp_reg_r  <= temp_reg_nxt;
            lb_reg_r    <= lb_reg_nxt;
            fault_r     <= fault_nxt;
            st_r        <= st_nxt;
            code_a_r    <= code_a_nxt;
            code_b_r    <= code_b_nxt;
            blank_d_r   <= blank_d_nxt;
            step_cnt_r  <= step_cnt_nxt;
            lb_cnt_r    <= lb_cnt_nxt;
            soft_cnt_r  <= soft_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        drive_out.code_a     = code_a_r;
        drive_out.code_b     = code_b_r;
        drive_out.en_a       = (st_r == FCP_ST_RUN) && event_on && ctrl_r[0];
        drive_out.en_b       = (st_r == FCP_ST_RUN) && event_on && ctrl_r[1];
        drive_out.hiz        = (st_r != FCP_ST_RUN) || !event_on; // RULE_17 RULE_18
        drive_out.boost_on   = (st_r == FCP_ST_SOFT) || (st_r == FCP_ST_RUN)
                               || (st_r == FCP_ST_TERM);
        drive_out.soft_start = (st_r == FCP_ST_SOFT); // RULE_19
        temp_thresh_code     = temp_reg_r[2:0]; // RULE_08
    end

endmodule
`default_nettype wire

// [sim/fcp_ctrl_checker.sv]
// fcp_ctrl_checker.sv: port-level assertions for fcp_ctrl.
// assumes binding to fcp_ctrl, one clock pclk, async reset presetn.
`timescale 1ns/1ps
`default_nettype none

module fcp_ctrl_checker import fcp_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        pa_blank_input,
    input wire fcp_sense_t  sense_in,
    input wire fcp_drive_t  drive_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [9:0] soft_cnt_r;
    logic [9:0] soft_cnt_nxt;

    always_comb begin
        soft_cnt_nxt = drive_out.soft_start ? soft_cnt_r + 10'h001 : 10'h000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_cnt_r <= 10'h000;
        end else begin
            soft_cnt_r <= soft_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_out_of_reset: assert property ($rose(presetn) |-> drive_out.hiz
        && !drive_out.boost_on && !drive_out.en_a && drive_out.code_a == 5'h00)
        else $error("sinks not parked after reset");
    a_apb_ready: assert property (psel && penable |-> pready && !pslverr)
        else $error("access phase not completed cleanly");
    a_unmapped_zero: assert property (psel && penable && !pwrite && paddr >= 12'h020
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_blank_floor: assert property ($rose(pa_blank_input) |->
        ##[1:5] (drive_out.code_a == 5'h00 && drive_out.code_b == 5'h00))
        else $error("blank onset did not drop codes");
    a_blank_step: assert property (pa_blank_input [*8] ##0
        (drive_out.code_a != $past(drive_out.code_a)) |->
        (drive_out.code_a == $past(drive_out.code_a) + 5'h01 ||
         drive_out.code_a == $past(drive_out.code_a) - 5'h01))
        else $error("blank step larger than one");
    a_lim_down: assert property ((pa_blank_input && sense_in.lim_over) [*4] |->
        drive_out.code_a < $past(drive_out.code_a) || drive_out.code_a == 5'h00)
        else $error("limit high but code not lowered");
    a_hiz_off: assert property (drive_out.hiz |-> !drive_out.en_a && !drive_out.en_b)
        else $error("sink enabled while high impedance");
    a_soft_bound: assert property (soft_cnt_r <= 10'h19A)
        else $error("soft start too long");

    c_limit: cover property (pa_blank_input && sense_in.lim_over);
    c_soft: cover property (drive_out.soft_start);
    c_lowbat: cover property (sense_in.lowbat_low && !pa_blank_input);
endmodule
`default_nettype wire

// [sim/fcp_far_model.sv]
// fcp_far_model.sv: behavioural comparators and PA enable facing fcp_ctrl.
// assumes the bench sets the limits and fault levels; slow answers every 4th edge.
`timescale 1ns/1ps
`default_nettype none

module fcp_far_model import fcp_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       pa_on,
    input  wire logic       slow,
    input  wire fcp_drive_t drive,
    input  wire logic [5:0] lim_cap,
    input  wire fcp_code_t  lb_cap,
    input  wire logic [4:0] faults,
    output var logic        pa_pin,
    output var fcp_sense_t  sense
);
    logic [1:0] div;
    logic       over;
    logic       low;

    initial begin
        div = 2'h0;
        pa_pin = 1'b0;
        sense = '0;
    end

    // input current grows with the sum of both codes
    assign over = pa_on && ({1'b0, drive.code_a} + {1'b0, drive.code_b} > lim_cap);
    assign low  = drive.code_a > lb_cap;

    always @(posedge pclk) begin
        div <= div + 2'h1;
        pa_pin <= pa_on;
        if (!slow || div == 2'h0) begin
            sense <= {over, low, !low, faults};
        end
    end
endmodule
`default_nettype wire

// [sim/tb_fcp_ctrl.sv]
// tb_fcp_ctrl.sv: self-checking bench for fcp_ctrl over APB with the far model.
// assumes fcp_pkg, fcp_ctrl, fcp_far_model and fcp_ctrl_checker compiled before.
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defines.svh"

module tb_fcp_ctrl import fcp_pkg::*;;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pa_pin, in_uvlo, pa_on, slow;
    logic [2:0]  thr;
    logic [5:0]  lim_cap;
    fcp_code_t   lb_cap;
    logic [4:0]  faults;
    fcp_sense_t  sense;
    fcp_drive_t  drive;
    int          bad_count, n_checks;

    always #2.5 pclk = ~pclk;

    fcp_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pa_blank_input(pa_pin), .in_uvlo(in_uvlo), .sense_in(sense),
        .drive_out(drive), .temp_thresh_code(thr));
    fcp_far_model far (.pclk(pclk), .pa_on(pa_on), .slow(slow), .drive(drive),
        .lim_cap(lim_cap), .lb_cap(lb_cap), .faults(faults), .pa_pin(pa_pin), .sense(sense));

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic stall();
        bad_count++;
        $display("BAD %0t wait ran out", $time);
        give_verdict();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) stall();
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic wait_a(input fcp_code_t v, input int n, output int c);
        c = 0;
        while (drive.code_a !== v && c < n) begin
            @(posedge pclk);
            c++;
        end
        if (drive.code_a !== v) stall();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        presetn <= 1'b0;
        idle(12);
        presetn <= 1'b1;
        idle(1);
        chk({28'h0, drive.hiz, drive.boost_on, drive.en_a, drive.en_b}, 32'h8);
        chk({27'h0, drive.code_a}, 32'h0);
        for (int i = 0; i < 7; i++) rd(12'(i * 4), 32'h0);
        rd(`FCP_OFF_STATUS, 32'h400);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        rd(12'h020, 32'h0);
    endtask

    task automatic t_start();
        apb(1'b1, `FCP_OFF_SINK_A, 32'h10);
        apb(1'b1, `FCP_OFF_SINK_B, 32'h08);
        apb(1'b1, `FCP_OFF_CTRL, 32'h17);
        idle(4);
        chk({31'h0, drive.soft_start}, 32'h1);
        idle(420);
        chk({22'h0, drive.code_a, drive.code_b}, 32'h208);
        chk({28'h0, drive.hiz, drive.boost_on, drive.en_a, drive.en_b}, 32'h7);
    endtask

    task automatic t_steps();
        int c;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `FCP_OFF_BLANK, 32'(s));
            pa_on <= 1'b1;
            wait_a(5'h00, 8, c);
            wait_a(5'h01, 2000, c);
            chk(32'(c >= (200 << s) - 5 && c <= (200 << s) + 5), 32'h1);
            chk({27'h0, drive.code_b}, 32'h1);
            pa_on <= 1'b0;
            wait_a(5'h10, 8, c);
        end
    endtask

    task automatic t_limit();
        int c;
        int top;
        top = 0;
        apb(1'b1, `FCP_OFF_BLANK, 32'h0);
        lim_cap <= 6'h05;
        pa_on <= 1'b1;
        wait_a(5'h00, 8, c);
        for (int i = 0; i < 2000; i++) begin
            @(posedge pclk);
            if (drive.code_a > top) top = drive.code_a;
        end
        chk(32'(top), 32'h3);
        rd(`FCP_OFF_SINK_A, 32'h10);
        pa_on <= 1'b0;
        wait_a(5'h10, 8, c);
        chk({27'h0, drive.code_b}, 32'h8);
        lim_cap <= 6'h3F;
    endtask

    task automatic t_pol();
        int c;
        apb(1'b1, `FCP_OFF_BLANK, 32'h40);
        wait_a(5'h00, 8, c);
        apb(1'b1, `FCP_OFF_BLANK, 32'h0);
        wait_a(5'h10, 8, c);
    endtask

    task automatic t_lowbat();
        int c;
        int top;
        top = 0;
        slow <= 1'b1;
        apb(1'b1, `FCP_OFF_CTRL, 32'h1B);
        apb(1'b1, `FCP_OFF_LOWBAT, 32'h0C);
        lb_cap <= 5'h0D;
        wait_a(5'h0F, 1000, c);
        idle(5000);
        chk({27'h0, drive.code_a}, 32'hD);
        apb(1'b1, `FCP_OFF_LOWBAT, 32'h0);
        for (int i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if (drive.code_a > top) top = drive.code_a;
        end
        chk(32'(top), 32'hE);
        lb_cap <= 5'h1F;
        slow <= 1'b0;
        apb(1'b1, `FCP_OFF_CTRL, 32'h17);
    endtask

    task automatic t_temp();
        for (int t = 0; t < 8; t++) begin
            apb(1'b1, `FCP_OFF_TEMP, 32'(t));
            idle(2);
            chk({29'h0, thr}, 32'(t));
        end
        faults <= 5'h10;
        idle(8);
        rd(`FCP_OFF_FAULT, 32'h0);
        apb(1'b1, `FCP_OFF_TEMP, 32'h0D);
        idle(8);
        rd(`FCP_OFF_FAULT, 32'h8);
        apb(1'b0, `FCP_OFF_STATUS, 32'h0);
        chk({28'h0, q[13:10]}, 32'h8);
        faults <= 5'h00;
        idle(8);
        rd(`FCP_OFF_FAULT, 32'h8);
        apb(1'b1, `FCP_OFF_FAULT, 32'h8);
        rd(`FCP_OFF_FAULT, 32'h0);
        apb(1'b1, `FCP_OFF_CTRL, 32'h13);
    endtask

    task automatic t_fault();
        apb(1'b1, `FCP_OFF_CTRL, 32'h16);
        faults <= 5'h09;
        idle(8);
        rd(`FCP_OFF_FAULT, 32'h20);
        apb(1'b1, `FCP_OFF_CTRL, 32'h17);
        idle(8);
        rd(`FCP_OFF_FAULT, 32'h21);
        faults <= 5'h00;
        idle(8);
        apb(1'b1, `FCP_OFF_FAULT, 32'h21);
        rd(`FCP_OFF_FAULT, 32'h0);
        in_uvlo <= 1'b1;
        idle(20);
        in_uvlo <= 1'b0;
        rd(`FCP_OFF_SINK_A, 32'h10);
        rd(`FCP_OFF_CTRL, 32'h17);
        chk({31'h0, drive.soft_start}, 32'h1);
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        stall();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        in_uvlo = 1'b0;
        pa_on = 1'b0;
        slow = 1'b0;
        lim_cap = 6'h3F;
        lb_cap = 5'h1F;
        faults = 5'h00;
        bad_count = 0;
        n_checks = 0;
        t_reset();
        t_start();
        t_steps();
        t_limit();
        t_pol();
        t_lowbat();
        t_temp();
        t_fault();
        t_reset();
        give_verdict();
    end
endmodule

bind fcp_ctrl fcp_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pa_blank_input(pa_blank_input), .sense_in(sense_in),
    .drive_out(drive_out));
`default_nettype wire
